/* core/hwk_pkg.sv */
package hwk_pkg;
   // Clock and filter timing
   localparam int CLK_HZ = 50000000;
   localparam int FILTER_TIME_US = 16;
   localparam int FILTER_CYCLES = (FILTER_TIME_US * (CLK_HZ / 1000000));
   localparam int FILT_W = 10;

   // Pull select codes
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;
   localparam logic [1:0] PULL_AUTO = 2'h3;
   localparam logic [1:0] PULL_RESET = 2'h0;

   // Device operating modes
   typedef enum logic [2:0] {
      HWK_MODE_INIT,
      HWK_MODE_NORMAL,
      HWK_MODE_STOP,
      HWK_MODE_SLEEP,
      HWK_MODE_FAILSAFE
   } hwk_mode_t;

   // Software control bits
   typedef struct packed {
      logic wake_enable_ctrl;
      logic cyclic_mode;
      logic [1:0] wake_pull_ctrl;
      logic hv_measure_enable;
      logic alt_wake_enable;
   } hwk_ctrl_t;

   // Pull source drive
   typedef struct packed {
      logic pull_up_on;
      logic pull_down_on;
   } hwk_pull_t;
endpackage : hwk_pkg

/* core/hwk_filter.sv */
`timescale 1ns/1ns
// Synchronised input with restartable deglitch; emits a pulse per accepted edge
module hwk_filter (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic pin_in,
   input wire logic gate,
   output logic level,
   output logic edge_pulse
);
   logic sync1_reg;
   logic sync2_reg;
   logic raw_reg;
   logic level_reg;
   logic edge_reg;
   logic [hwk_pkg::FILT_W-1:0] cnt_reg;

   // Two-stage synchroniser
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Any crossing restarts the interval; stable for the full time is accepted
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         raw_reg <= 1'b0;
         level_reg <= 1'b0;
         cnt_reg <= '0;
         edge_reg <= 1'b0;
      end else begin
         raw_reg <= sync2_reg;
         edge_reg <= 1'b0;
         if (gate) begin
            cnt_reg <= '0;
            level_reg <= sync2_reg; // Track quietly while gated, no event
         end else if (sync2_reg != raw_reg) begin
            cnt_reg <= '0;
         end else if (sync2_reg != level_reg) begin
            if (cnt_reg == hwk_pkg::FILT_W'(hwk_pkg::FILTER_CYCLES - 1))
            begin
               level_reg <= sync2_reg;
               edge_reg <= 1'b1;
               cnt_reg <= '0;
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end else begin
            cnt_reg <= '0; // Short pulse returned: discarded
         end
      end
   end

   assign level = level_reg;
   assign edge_pulse = edge_reg;
endmodule : hwk_filter

/* core/hwk_detector.sv */
`timescale 1ns/1ns
module hwk_detector (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic hv_wake_input,
   input wire logic fail_out_general_pin,
   input wire logic timed_high_side_output,
   input wire hwk_pkg::hwk_mode_t mode,
   input wire hwk_pkg::hwk_ctrl_t ctrl,
   input wire logic wake_flag_clear,
   input wire logic alt_flag_clear,
   output logic wake_pin_event_flag,
   output logic alt_wake_event_status,
   output logic wake_level_status,
   output logic irq_req,
   output logic wake_req,
   output hwk_pkg::hwk_pull_t pull
);
   logic static_lvl;
   logic static_edge;
   logic alt_lvl;
   logic alt_edge;
   logic gate_static;
   logic gate_alt;
   logic hs_sync1_reg;
   logic hs_on_reg;
   logic hs_prev_reg;
   logic samp_sync1_reg;
   logic samp_live_reg;
   logic sampled_reg;
   logic sample_valid_reg;
   logic cyc_edge;
   logic cyc_active;
   logic win_close;
   logic wake_event;
   logic flag_reg;
   logic alt_reg;
   logic lvl_reg;
   logic irq_reg;
   logic wake_reg;
   hwk_pkg::hwk_pull_t pull_reg;

   // True when the device is in a mode that reports by interrupt
   function automatic logic is_irq_mode(input hwk_pkg::hwk_mode_t m);
      return (m == hwk_pkg::HWK_MODE_NORMAL) ||
             (m == hwk_pkg::HWK_MODE_STOP);
   endfunction : is_irq_mode

   // True when an event must wake the device rather than interrupt it
   function automatic logic is_wake_mode(input hwk_pkg::hwk_mode_t m);
      return (m == hwk_pkg::HWK_MODE_SLEEP) ||
             (m == hwk_pkg::HWK_MODE_FAILSAFE);
   endfunction : is_wake_mode

   // Modes in which the live level is published; it holds elsewhere
   function automatic logic shows_level(input hwk_pkg::hwk_mode_t m);
      return is_irq_mode(m) || (m == hwk_pkg::HWK_MODE_INIT);
   endfunction : shows_level

   // Source select for one pull code; auto follows the filtered level
   function automatic hwk_pkg::hwk_pull_t pull_decode(
      input logic [1:0] code,
      input logic lvl
   );
      hwk_pkg::hwk_pull_t p;
      p = '0;
      case (code)
         hwk_pkg::PULL_NONE: p = '0;
         hwk_pkg::PULL_DOWN: p.pull_down_on = 1'b1;
         hwk_pkg::PULL_UP: p.pull_up_on = 1'b1;
         hwk_pkg::PULL_AUTO: begin
            p.pull_up_on = lvl;
            p.pull_down_on = ~lvl;
         end
         default: p = '0;
      endcase
      return p;
   endfunction : pull_decode

   // Static filter is idle in cyclic sense or measurement mode
   assign gate_static = ctrl.cyclic_mode | ctrl.hv_measure_enable;
   assign gate_alt = ~ctrl.alt_wake_enable | ctrl.hv_measure_enable;

   hwk_filter u_main_filter (
      .mclk(mclk),
      .resetn(resetn),
      .pin_in(hv_wake_input),
      .gate(gate_static),
      .level(static_lvl),
      .edge_pulse(static_edge)
   );

   // Alternate pin uses the same static filter
   hwk_filter u_alt_filter (
      .mclk(mclk),
      .resetn(resetn),
      .pin_in(fail_out_general_pin),
      .gate(gate_alt),
      .level(alt_lvl),
      .edge_pulse(alt_edge)
   );

   // Synchronise the window strobe and pin for cyclic sampling. This pair
   // is separate from the filter's own, so the cyclic and static views of
   // one crossing may land a cycle apart; neither view feeds the other.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hs_sync1_reg <= 1'b0;
         hs_on_reg <= 1'b0;
         hs_prev_reg <= 1'b0;
         samp_sync1_reg <= 1'b0;
         samp_live_reg <= 1'b0;
      end else begin
         hs_sync1_reg <= timed_high_side_output;
         hs_on_reg <= hs_sync1_reg;
         hs_prev_reg <= hs_on_reg;
         samp_sync1_reg <= hv_wake_input;
         samp_live_reg <= samp_sync1_reg;
      end
   end

   // Cyclic sense runs only while measurement leaves the pin alone
   assign cyc_active = ctrl.cyclic_mode & ~ctrl.hv_measure_enable;
   // End of an on-time: the synchronised window has just fallen
   assign win_close = hs_prev_reg & ~hs_on_reg;

   // Sample at the end of each on-time; no evaluation outside the window
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sampled_reg <= 1'b0;
         sample_valid_reg <= 1'b0;
      end else if (!cyc_active) begin
         sample_valid_reg <= 1'b0;
      end else if (win_close) begin
         sampled_reg <= samp_live_reg;
         sample_valid_reg <= 1'b1;
      end
   end

   // First sample only sets a reference, so entering cyclic mode is silent
   assign cyc_edge = cyc_active && win_close && sample_valid_reg &&
                     (samp_live_reg != sampled_reg);

   assign wake_event = (static_edge | cyc_edge) & ctrl.wake_enable_ctrl;

   // Sticky flags; a new event wins over a clear in the same cycle
   // Limitation: each flag remembers only that something happened, not how
   // many events arrived before software read it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flag_reg <= 1'b0;
         alt_reg <= 1'b0;
      end else begin
         if (wake_event) begin
            flag_reg <= 1'b1;
         end else if (wake_flag_clear) begin
            flag_reg <= 1'b0;
         end
         if (alt_edge) begin
            alt_reg <= 1'b1;
         end else if (alt_flag_clear) begin
            alt_reg <= 1'b0;
         end
      end
   end

   // Level view: live filtered, or sampled in cyclic, cleared when measuring
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         lvl_reg <= 1'b0;
      end else if (ctrl.hv_measure_enable) begin
         lvl_reg <= 1'b0;
      end else if (ctrl.cyclic_mode) begin
         lvl_reg <= sampled_reg;
      end else if (shows_level(mode)) begin
         lvl_reg <= static_lvl;
      end
   end

   // One-cycle interrupt or wake request depending on mode
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         irq_reg <= wake_event && is_irq_mode(mode);
         wake_reg <= wake_event && is_wake_mode(mode);
      end
   end

   // Pull sources; auto follows the filtered level to avoid chatter
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pull_reg <= '0;
      end else if (ctrl.hv_measure_enable) begin
         pull_reg <= '0;
      end else begin
         pull_reg <= pull_decode(ctrl.wake_pull_ctrl, static_lvl);
      end
   end

   assign wake_pin_event_flag = flag_reg;
   assign alt_wake_event_status = alt_reg;
   assign wake_level_status = lvl_reg;
   assign irq_req = irq_reg;
   assign wake_req = wake_reg;
   assign pull = pull_reg;
endmodule : hwk_detector

/* test/hwk_detector_monitor.sv */
`timescale 1ns/1ns
// Port checker for the wake pin detector
module hwk_detector_monitor (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic hv_wake_input,
   input wire logic fail_out_general_pin,
   input wire logic timed_high_side_output,
   input wire hwk_pkg::hwk_mode_t mode,
   input wire hwk_pkg::hwk_ctrl_t ctrl,
   input wire logic wake_flag_clear,
   input wire logic alt_flag_clear,
   input wire logic wake_pin_event_flag,
   input wire logic alt_wake_event_status,
   input wire logic wake_level_status,
   input wire logic irq_req,
   input wire logic wake_req,
   input wire hwk_pkg::hwk_pull_t pull
);
   logic [11:0] quiet_reg;
   logic pin_d_reg;
   // Stable pin cycles, saturating so long idles never wrap
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         quiet_reg <= 12'h000;
         pin_d_reg <= 1'b0;
      end else begin
         pin_d_reg <= hv_wake_input;
         if (hv_wake_input != pin_d_reg)
            quiet_reg <= 12'h000;
         else if (quiet_reg != 12'hfff)
            quiet_reg <= quiet_reg + 12'h001;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_irq_mode: assert property (
      irq_req |-> $past(mode) inside {hwk_pkg::HWK_MODE_NORMAL,
      hwk_pkg::HWK_MODE_STOP}) else $error("irq in wrong mode");
   a_wake_mode: assert property (
      wake_req |-> $past(mode) inside {hwk_pkg::HWK_MODE_SLEEP,
      hwk_pkg::HWK_MODE_FAILSAFE}) else $error("wake in wrong mode");
   a_req_enabled: assert property (
      irq_req || wake_req |-> $past(ctrl.wake_enable_ctrl) &&
      wake_pin_event_flag)
      else $error("request without enable or flag");
   a_req_pulse: assert property (
      irq_req || wake_req |=> !irq_req && !wake_req)
      else $error("request longer than one cycle");
   a_flag_sticky: assert property (
      wake_pin_event_flag && !wake_flag_clear |=> wake_pin_event_flag)
      else $error("event flag dropped");
   a_glitch_drop: assert property (
      $rose(wake_pin_event_flag) && !ctrl.cyclic_mode
      |-> quiet_reg >= hwk_pkg::FILTER_CYCLES - 2)
      else $error("event before filter time");
   a_meas_quiet: assert property (
      ctrl.hv_measure_enable && $past(ctrl.hv_measure_enable)
      |-> pull == 2'h0 && !wake_level_status)
      else $error("measure mode leaks pull or level");
   a_pull_code: assert property (
      !ctrl.hv_measure_enable && $stable(ctrl) && ctrl.wake_pull_ctrl !=
      hwk_pkg::PULL_AUTO |-> pull == ctrl.wake_pull_ctrl)
      else $error("pull code decode");
   c_irq: cover property (irq_req);
   c_wake: cover property (wake_req);
   c_alt: cover property ($rose(alt_wake_event_status));
endmodule : hwk_detector_monitor

bind hwk_detector hwk_detector_monitor hwk_detector_monitor_i (
   .mclk(mclk), .resetn(resetn), .hv_wake_input(hv_wake_input),
   .fail_out_general_pin(fail_out_general_pin), .mode(mode), .ctrl(ctrl),
   .timed_high_side_output(timed_high_side_output), .pull(pull),
   .wake_flag_clear(wake_flag_clear), .alt_flag_clear(alt_flag_clear),
   .wake_pin_event_flag(wake_pin_event_flag), .irq_req(irq_req),
   .alt_wake_event_status(alt_wake_event_status), .wake_req(wake_req),
   .wake_level_status(wake_level_status));

/* test/hwk_pin_model.sv */
`timescale 1ns/1ns
// Switch line at the wake pin; a released line follows the pull source
module hwk_pin_model (
   input wire logic mclk,
   input wire logic drv_en,
   input wire logic drv_val,
   input wire hwk_pkg::hwk_pull_t pull,
   output logic pin
);
   logic wander_reg;
   initial wander_reg = 1'b0;
   // A floating pin wanders, so nothing may trust its level
   always @(posedge mclk)
      wander_reg <= !wander_reg;
   // Resolve the line from the switch and the current sources
   always_comb begin
      if (drv_en)
         pin = drv_val;
      else if (pull.pull_up_on)
         pin = 1'b1;
      else if (pull.pull_down_on)
         pin = 1'b0;
      else
         pin = wander_reg;
   end
endmodule : hwk_pin_model

/* test/hv_wake_input_detector_test.sv */
`timescale 1ns/1ns
// Self-checking bench for the wake pin detector
module hv_wake_input_detector_test;
   localparam int F = hwk_pkg::FILTER_CYCLES;
   logic mclk, resetn, drv_en, drv_val, alt_pin, hs_win, wclr, aclr;
   logic flag, aflag, lvl, irq, wake, pin;
   hwk_pkg::hwk_mode_t mode;
   hwk_pkg::hwk_ctrl_t ctrl;
   hwk_pkg::hwk_pull_t pull;
   int n_fail, compares, n_irq, n_wake, e_irq, e_wake, e_flag, e_lvl;
   int cyc, ev_irq;
   hwk_pkg::hwk_mode_t modes[$] = '{hwk_pkg::HWK_MODE_NORMAL,
      hwk_pkg::HWK_MODE_STOP, hwk_pkg::HWK_MODE_SLEEP,
      hwk_pkg::HWK_MODE_FAILSAFE};
   hwk_pin_model hwk_pin_model_i (.mclk(mclk), .drv_en(drv_en),
      .drv_val(drv_val), .pull(pull), .pin(pin));
   hwk_detector hwk_detector_i (.mclk(mclk), .resetn(resetn),
      .hv_wake_input(pin), .fail_out_general_pin(alt_pin),
      .timed_high_side_output(hs_win), .mode(mode), .ctrl(ctrl),
      .wake_flag_clear(wclr), .alt_flag_clear(aclr),
      .wake_pin_event_flag(flag), .alt_wake_event_status(aflag),
      .wake_level_status(lvl), .irq_req(irq), .wake_req(wake),
      .pull(pull));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = !mclk;
   end
   // Count request pulses; the cycle ceiling cuts a hang short
   always @(posedge mclk) begin
      cyc++;
      if (irq === 1'b1) n_irq++;
      if (wake === 1'b1) n_wake++;
      if (cyc == 30000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   // Flip the pin, hold it, then compare with the predicted reports
   task automatic flip(int len);
      @(posedge mclk) drv_val <= !drv_val;
      repeat (len) @(posedge mclk);
      if (len > F + 8 && drv_val != e_lvl && !ctrl.cyclic_mode) begin
         e_lvl = drv_val;
         if (ctrl.wake_enable_ctrl && !ctrl.hv_measure_enable) begin
            e_flag = 1;
            if (ev_irq) e_irq++;
            else e_wake++;
         end
      end
      check("irq", n_irq[7:0], e_irq[7:0]);
      check("wake", n_wake[7:0], e_wake[7:0]);
      check("flag", flag, e_flag[7:0]);
   endtask : flip
   // One cyclic sense on-time window
   task automatic window();
      @(posedge mclk) hs_win <= 1'b1;
      repeat (10) @(posedge mclk);
      hs_win <= 1'b0;
      repeat (12) @(posedge mclk);
   endtask : window
   initial begin
      resetn = 1'b0;
      drv_en = 1'b1;
      drv_val = 1'b0;
      alt_pin = 1'b0;
      hs_win = 1'b0;
      wclr = 1'b0;
      aclr = 1'b0;
      mode = hwk_pkg::HWK_MODE_NORMAL;
      ctrl = 6'h21;
      void'($urandom(57));
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      // Per mode: one glitch shorter than the filter, a short return to level, then a real edge
      foreach (modes[i]) begin
         mode <= modes[i];
         ev_irq = (i < 2);
         flip($urandom_range(F - 10, F / 2 + 10));
         flip($urandom_range(F - 10, F / 2 + 10));
         flip(F + 20 + $urandom_range(40));
         @(posedge mclk) wclr <= 1'b1;
         @(posedge mclk) wclr <= 1'b0;
         e_flag = 0;
      end
      mode <= hwk_pkg::HWK_MODE_NORMAL;
      ev_irq = 1;
      ctrl.wake_enable_ctrl <= 1'b0;
      flip(F + 30);
      check("level", lvl, e_lvl[7:0]);
      ctrl <= 6'h2f;
      repeat (3) @(posedge mclk);
      check("meas hold", lvl, 8'h00);
      check("meas off", pull, 8'h00);
      flip(F + 30);
      check("meas level", lvl, 8'h00);
      check("meas pull", pull, 8'h00);
      ctrl.hv_measure_enable <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         ctrl.wake_pull_ctrl <= c[1:0];
         repeat (900) @(posedge mclk);
         check("pull", pull, c == 3 ? 8'(e_lvl + 1) : c[7:0]);
      end
      // Let go of the pin: only the current sources now set its level
      drv_en <= 1'b0;
      repeat (F + 20) @(posedge mclk);
      check("float lvl", lvl, e_lvl[7:0]);
      ctrl.wake_pull_ctrl <= hwk_pkg::PULL_UP;
      repeat (F + 20) @(posedge mclk);
      e_lvl = 1;
      e_flag = 1;
      e_irq++;
      ctrl.wake_pull_ctrl <= hwk_pkg::PULL_AUTO;
      repeat (4) @(posedge mclk);
      check("pull up irq", n_irq[7:0], e_irq[7:0]);
      check("pull up flag", flag, e_flag[7:0]);
      check("auto high", pull, 8'h02);
      drv_val <= 1'b1;
      drv_en <= 1'b1;
      @(posedge mclk) alt_pin <= 1'b1;
      repeat (F + 20) @(posedge mclk);
      check("alt", aflag, 8'h01);
      check("alt no irq", n_irq[7:0], e_irq[7:0]);
      @(posedge mclk) aclr <= 1'b1;
      @(posedge mclk) aclr <= 1'b0;
      @(posedge mclk) check("alt clr", aflag, 8'h00);
      ctrl.cyclic_mode <= 1'b1;
      window();
      flip(F + 20);
      check("cyc hold", lvl, e_lvl[7:0]);
      window();
      e_lvl = drv_val;
      e_irq++;
      check("cyc irq", n_irq[7:0], e_irq[7:0]);
      check("cyc level", lvl, e_lvl[7:0]);
      complete_run();
   end
endmodule : hv_wake_input_detector_test
